// *** hdl/bpc_branch_ctrl.sv ***
`timescale 1ns/1ps
// How it works
// RL1: A wrong guess is flagged the cycle after its compare; fetch restarts the cycle after.
// RL2: Once the loop count register is loaded, a count-only branch ignores all predictors.
// RL3: Count-register loop exits are always predicted right, with no learned history.
// RL4: A count reaching zero falls through, with no mispredict and no taken bubble.
// RL5: A count move is forwarded to the branch unit long before the move completes.
// RL6: A count or link move forwards once in complex integer unit station 0 with source ready.
// RL7: With dynamic prediction off, the opcode hint decides and the table is not used.
// RL8: With dynamic prediction on, counters learn a branch's usual direction and re-adapt.
// RL9: A mostly taken loop branch is predicted taken, so each loop exit mispredicts.
// RL10: On a mispredict, wrong-path work is flushed before fetch resumes at the right address.
module bpc_branch_ctrl (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        cfg_dyn_pred_en,
	input  wire logic        br_valid,
	input  wire logic [31:0] br_pc,
	input  wire logic [31:0] br_target,
	input  wire logic [31:0] br_fallthru,
	input  wire logic        br_hint,
	input  wire logic        br_is_count,
	output logic             br_ready,
	output logic             pred_valid,
	output logic             pred_taken,
	output logic             pred_exact,
	output logic      [31:0] pred_addr,
	input  wire logic        cmp_valid,
	input  wire logic        cmp_taken,
	output logic             mispredict,
	output logic             flush,
	output logic             restart_valid,
	output logic      [31:0] restart_addr,
	input  wire logic        mv_dispatch,
	input  wire logic        mv_dispatch_link,
	input  wire logic        mv_in_rs0,
	input  wire logic        mv_src_ready,
	input  wire logic        mv_is_link,
	input  wire logic [31:0] mv_src,
	output logic             count_valid,
	output logic      [31:0] count_value,
	output logic             link_fwd_valid,
	output logic      [31:0] link_fwd_value
);

	// ************************************************************
	// State.
	// ************************************************************
	typedef struct packed {
		bpc_pkg::bpc_state_t           st;
		logic                          br_ready;
		logic                          pred_valid;
		logic                          pred_taken;
		logic                          pred_exact;
		logic [31:0]                   pred_addr;
		logic                          mispredict;
		logic                          flush;
		logic                          restart_valid;
		logic [31:0]                   restart_addr;
		logic                          cnt_ok;
		logic [31:0]                   cnt_val;
		logic                          link_ok;
		logic [31:0]                   link_val;
		logic                          is_count;
		logic                          hint;
		logic [31:0]                   target;
		logic [31:0]                   fallthru;
		logic                          taken_q;
		logic [bpc_pkg::BHT_CTR_W-1:0] old_ctr;
		logic [bpc_pkg::BHT_IDX_W-1:0] idx;
		logic                          upd_en;
		logic [bpc_pkg::BHT_IDX_W-1:0] upd_idx;
		logic [bpc_pkg::BHT_CTR_W-1:0] upd_ctr;
	} bpc_ctl_t;

	bpc_ctl_t                      s_r;
	bpc_ctl_t                      s_nxt;
	logic [bpc_pkg::BHT_CTR_W-1:0] bht_rdata;
	logic [bpc_pkg::BHT_IDX_W-1:0] rd_idx;
	logic                          fwd_cnt;
	logic                          fwd_link;
	logic                          accept;
	logic [31:0]                   cnt_dec;

	// A count that lands on zero ends the loop.
	localparam logic [31:0] CNT_ZERO = 32'h0000_0000;

	assign br_ready       = s_r.br_ready;
	assign pred_valid     = s_r.pred_valid;
	assign pred_taken     = s_r.pred_taken;
	assign pred_exact     = s_r.pred_exact;
	assign pred_addr      = s_r.pred_addr;
	assign mispredict     = s_r.mispredict;
	assign flush          = s_r.flush;
	assign restart_valid  = s_r.restart_valid;
	assign restart_addr   = s_r.restart_addr;
	assign count_valid    = s_r.cnt_ok;
	assign count_value    = s_r.cnt_val;
	assign link_fwd_valid = s_r.link_ok;
	assign link_fwd_value = s_r.link_val;

	// ************************************************************
	// History table.
	// ************************************************************
	assign rd_idx = br_pc[bpc_pkg::BHT_IDX_LSB +: bpc_pkg::BHT_IDX_W];

	bpc_bht_mem u_bht (
		.sys_clk (sys_clk),
		.reset   (reset),
		.rd_idx  (rd_idx),
		.rd_data (bht_rdata),
		.wr_en   (s_r.upd_en),
		.wr_idx  (s_r.upd_idx),
		.wr_data (s_r.upd_ctr)
	);

	// Forwarding is decided here, not at completion, so a waiting loop branch
	// can go long before the serialized move retires.
	assign fwd_cnt  = mv_in_rs0 && mv_src_ready && !mv_is_link; // see RL6
	assign fwd_link = mv_in_rs0 && mv_src_ready && mv_is_link;  // see RL6
	assign cnt_dec  = s_r.cnt_val - bpc_pkg::CNT_ONE;
	// A count branch waits while the count is stale or about to change.
	assign accept   = br_valid && s_r.br_ready &&
		(!br_is_count || (s_r.cnt_ok && !fwd_cnt && !mv_dispatch)); // see RL2

	// ************************************************************
	// Sequencer.
	// ************************************************************
	// Pulses default low; the forwarded registers update first and a newly
	// dispatched move then invalidates the copy, since it is younger.
	always_comb begin
		s_nxt               = s_r;
		s_nxt.pred_valid    = 1'b0;
		s_nxt.mispredict    = 1'b0;
		s_nxt.flush         = 1'b0;
		s_nxt.restart_valid = 1'b0;
		s_nxt.upd_en        = 1'b0;
		if (fwd_cnt) begin
			s_nxt.cnt_val = mv_src; // see RL5
			s_nxt.cnt_ok  = 1'b1;
		end
		if (fwd_link) begin
			s_nxt.link_val = mv_src;
			s_nxt.link_ok  = 1'b1;
		end
		if (mv_dispatch) begin
			s_nxt.cnt_ok = 1'b0;
		end
		if (mv_dispatch_link) begin
			s_nxt.link_ok = 1'b0;
		end
		case (s_r.st)
			bpc_pkg::BPC_IDLE: begin
				if (accept) begin
					s_nxt.st       = bpc_pkg::BPC_LOOKUP;
					s_nxt.br_ready = 1'b0;
					s_nxt.is_count = br_is_count;
					s_nxt.hint     = br_hint;
					s_nxt.target   = br_target;
					s_nxt.fallthru = br_fallthru;
					s_nxt.idx      = rd_idx;
					if (br_is_count) begin
						// Direction is exact from the count itself.
						s_nxt.cnt_val = cnt_dec;                // see RL2
						s_nxt.taken_q = (cnt_dec != CNT_ZERO);  // see RL3
					end
				end
			end
			bpc_pkg::BPC_LOOKUP: begin
				s_nxt.pred_valid = 1'b1;
				if (s_r.is_count) begin
					// Every count pass, taken or final, is exact and needs no check later.
					s_nxt.st         = bpc_pkg::BPC_IDLE;
					s_nxt.br_ready   = 1'b1;
					s_nxt.pred_exact = 1'b1;
					s_nxt.pred_taken = s_r.taken_q;                          // see RL4
					s_nxt.pred_addr  = s_r.taken_q ? s_r.target : s_r.fallthru; // see RL4
				end else begin
					s_nxt.st         = bpc_pkg::BPC_WAIT;
					s_nxt.pred_exact = 1'b0;
					s_nxt.old_ctr    = bht_rdata;
					// Counter bit 1 wins for dynamic, opcode hint for static.
					s_nxt.taken_q    = cfg_dyn_pred_en ? bht_rdata[1] : s_r.hint; // see RL7
					s_nxt.pred_taken = s_nxt.taken_q;                              // see RL9
					s_nxt.pred_addr  = s_nxt.taken_q ? s_r.target : s_r.fallthru;
				end
			end
			bpc_pkg::BPC_WAIT: begin
				if (cmp_valid) begin
					// Training only when dynamic prediction is on.
					s_nxt.upd_en  = cfg_dyn_pred_en; // see RL7
					s_nxt.upd_idx = s_r.idx;
					s_nxt.upd_ctr = sat_step(s_r.old_ctr, cmp_taken); // see RL8
					if (cmp_taken != s_r.taken_q) begin
						s_nxt.st           = bpc_pkg::BPC_RESTART;
						s_nxt.mispredict   = 1'b1; // see RL1
						s_nxt.flush        = 1'b1; // see RL10
						s_nxt.restart_addr = cmp_taken ? s_r.target : s_r.fallthru;
					end else begin
						s_nxt.st       = bpc_pkg::BPC_IDLE;
						s_nxt.br_ready = 1'b1;
					end
				end
			end
			default: begin
				// Restart one cycle after the flush has cleared the wrong path.
				s_nxt.st            = bpc_pkg::BPC_IDLE;
				s_nxt.br_ready      = 1'b1;
				s_nxt.restart_valid = 1'b1; // see RL1
			end
		endcase
	end

	// Saturating two-bit counter step; two wrong outcomes flip a strong entry.
	function automatic logic [1:0] sat_step(input logic [1:0] c, input logic up);
		logic [1:0] r;
		r = c;
		if (up && (c != bpc_pkg::BHT_MAX)) begin
			r = c + bpc_pkg::BHT_ONE;
		end else if (!up && (c != bpc_pkg::BHT_MIN)) begin
			r = c - bpc_pkg::BHT_ONE;
		end
		return r;
	endfunction

	// State register.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_r              <= '0;
			s_r.st           <= bpc_pkg::BPC_IDLE;
			s_r.br_ready     <= 1'b1;
			s_r.cnt_val      <= bpc_pkg::CNT_RESET_VAL;
			s_r.pred_addr    <= bpc_pkg::ADDR_RESET_VAL;
			s_r.restart_addr <= bpc_pkg::ADDR_RESET_VAL;
			s_r.old_ctr      <= bpc_pkg::BHT_RESET_VAL;
			s_r.upd_ctr      <= bpc_pkg::BHT_RESET_VAL;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ************************************************************
	// Checks.
	// ************************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	logic misp_ev;
	logic cnt_acc;
	assign misp_ev = (s_r.st == bpc_pkg::BPC_WAIT) && cmp_valid && (cmp_taken != s_r.taken_q);
	assign cnt_acc = accept && br_is_count && (s_r.st == bpc_pkg::BPC_IDLE);

	AST_MISP_TIMING: assert property (misp_ev |=> mispredict && flush ##1 restart_valid) // see RL1
		else $error("mispredict or restart not on time");
	AST_RESTART_ADDR: assert property (misp_ev |=> ##1
		restart_addr == ($past(cmp_taken, 2) ? s_r.target : s_r.fallthru)) // see RL1
		else $error("restart address wrong");
	AST_COUNT_DIR: assert property (cnt_acc |=> ##1 pred_valid && pred_exact &&
		(pred_taken == ($past(s_r.cnt_val, 2) != bpc_pkg::CNT_ONE))) // see RL2
		else $error("count branch direction wrong");
	AST_COUNT_NO_MISP: assert property (cnt_acc |=> !mispredict [*3]) // see RL3
		else $error("count branch raised a mispredict");
	AST_FALL_THRU: assert property ((cnt_acc && s_r.cnt_val == bpc_pkg::CNT_ONE) |=> ##1
		!pred_taken && pred_addr == $past(br_fallthru, 2)) // see RL4
		else $error("final loop pass did not fall through");
	AST_FWD_EARLY: assert property ((fwd_cnt && !mv_dispatch) |=>
		count_valid && count_value == $past(mv_src)) // see RL6
		else $error("count move not forwarded from station zero");
	AST_STATIC_HINT: assert property ((s_r.st == bpc_pkg::BPC_LOOKUP && !s_r.is_count &&
		!cfg_dyn_pred_en) |=> pred_taken == $past(s_r.hint)) // see RL7
		else $error("static prediction ignored the hint");
	AST_STATIC_NO_TRAIN: assert property ((s_r.st == bpc_pkg::BPC_WAIT && cmp_valid &&
		!cfg_dyn_pred_en) |=> !s_r.upd_en) // see RL7
		else $error("table trained while static");
	AST_LEARN: assert property ((s_r.st == bpc_pkg::BPC_WAIT && cmp_valid && cfg_dyn_pred_en &&
		cmp_taken && s_r.old_ctr == 2'h1) |=> s_r.upd_en && s_r.upd_ctr == 2'h2) // see RL8
		else $error("counter did not learn");
	AST_LOOP_TAKEN: assert property ((s_r.st == bpc_pkg::BPC_LOOKUP && !s_r.is_count &&
		cfg_dyn_pred_en && bht_rdata == 2'h3) |=> pred_taken) // see RL9
		else $error("strong taken entry predicted not taken");
	AST_FLUSH_FIRST: assert property (restart_valid |-> $past(flush)) // see RL10
		else $error("restart without flush");

	COV_MISP: cover property (misp_ev ##2 restart_valid);
	COV_LOOP_EXIT: cover property (cnt_acc && s_r.cnt_val == bpc_pkg::CNT_ONE);
	COV_LINK_FWD: cover property (fwd_link ##1 link_fwd_valid);
	COV_STATIC: cover property (!cfg_dyn_pred_en && pred_valid && !pred_exact);

endmodule

// *** hdl/bpc_pkg.sv ***
// ************************************************************
// Shared constants for the branch prediction control block.
// ************************************************************
package bpc_pkg;

	// Address and table geometry.
	localparam int          ADDR_W      = 32;
	localparam int          BHT_IDX_W   = 6;
	localparam int          BHT_DEPTH   = 64;
	localparam int          BHT_CTR_W   = 2;
	localparam int          BHT_IDX_LSB = 2;

	// Two-bit saturating counter encodings; the upper bit is the direction.
	localparam logic [1:0]  BHT_RESET_VAL = 2'h1;
	localparam logic [1:0]  BHT_MAX       = 2'h3;
	localparam logic [1:0]  BHT_MIN       = 2'h0;
	localparam logic [1:0]  BHT_ONE       = 2'h1;

	// Values after reset of the forwarded special registers and addresses, and the count decrement step.
	localparam logic [31:0] CNT_RESET_VAL  = 32'h0000_0000;
	localparam logic [31:0] CNT_ONE        = 32'h0000_0001;
	localparam logic [31:0] ADDR_RESET_VAL = 32'h0000_0000;

	// Cycles from compare execution to the flag, and from the flag to restart.
	localparam int          MISP_FLAG_CYC    = 1;
	localparam int          MISP_RESTART_CYC = 1;

	// Sequencer states, Gray coded along idle, lookup, wait, restart.
	typedef enum logic [1:0] {
		BPC_IDLE    = 2'b00,
		BPC_LOOKUP  = 2'b01,
		BPC_WAIT    = 2'b11,
		BPC_RESTART = 2'b10
	} bpc_state_t;

endpackage

// *** hdl/bpc_bht_mem.sv ***
`timescale 1ns/1ps
// ************************************************************
// Branch history table: counters with a registered read port.
// ************************************************************
module bpc_bht_mem (
	input  wire logic                          sys_clk,
	input  wire logic                          reset,
	input  wire logic [bpc_pkg::BHT_IDX_W-1:0] rd_idx,
	output logic      [bpc_pkg::BHT_CTR_W-1:0] rd_data,
	input  wire logic                          wr_en,
	input  wire logic [bpc_pkg::BHT_IDX_W-1:0] wr_idx,
	input  wire logic [bpc_pkg::BHT_CTR_W-1:0] wr_data
);

	typedef struct packed {
		logic [bpc_pkg::BHT_DEPTH-1:0][bpc_pkg::BHT_CTR_W-1:0] cnt;
		logic [bpc_pkg::BHT_DEPTH-1:0]                          vld;
		logic [bpc_pkg::BHT_CTR_W-1:0]                          rdata;
	} bpc_bht_t;

	bpc_bht_t m_r;
	bpc_bht_t m_nxt;

	assign rd_data = m_r.rdata;

	// An entry never written since reset reads as the reset counter, so a reset
	// clears the table in one cycle without sweeping every entry.
	always_comb begin
		m_nxt = m_r;
		for (int i = 0; i < bpc_pkg::BHT_DEPTH; i++) begin
			if (wr_en && (wr_idx == i[bpc_pkg::BHT_IDX_W-1:0])) begin
				m_nxt.cnt[i] = wr_data;
				m_nxt.vld[i] = 1'b1;
			end
		end
		// A read of the entry being written sees the new value.
		if (wr_en && (wr_idx == rd_idx)) begin
			m_nxt.rdata = wr_data;
		end else if (m_r.vld[rd_idx]) begin
			m_nxt.rdata = m_r.cnt[rd_idx];
		end else begin
			m_nxt.rdata = bpc_pkg::BHT_RESET_VAL;
		end
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			m_r.cnt   <= '0;
			m_r.vld   <= '0;
			m_r.rdata <= bpc_pkg::BHT_RESET_VAL;
		end else begin
			m_r <= m_nxt;
		end
	end

endmodule

// *** bench/bpc_pipe_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// Fetch and integer pipe stand-in that resolves predicted branches.
// ************************************************************
module bpc_pipe_model (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       pred_valid,
	input  wire logic       pred_exact,
	input  wire logic       act_taken,
	input  wire logic [3:0] cmp_delay,
	output logic            cmp_valid,
	output logic            cmp_taken
);
	logic [4:0] wait_r;

	// The compare fires cmp_delay+2 cycles after a checked prediction.
	// Between compares the direction line toggles, so a stale value is never read as a result.
	always_ff @(posedge sys_clk) begin
		cmp_valid <= 1'b0;
		cmp_taken <= ~cmp_taken;
		if (reset) begin
			wait_r    <= 5'h00;
			cmp_taken <= 1'b0;
		end else if (pred_valid && !pred_exact) begin
			wait_r <= {1'b0, cmp_delay} + 5'h01;
		end else if (wait_r == 5'h01) begin
			cmp_valid <= 1'b1;
			cmp_taken <= act_taken;
			wait_r    <= 5'h00;
		end else if (wait_r != 5'h00) begin
			wait_r <= wait_r - 5'h01;
		end
	end
endmodule

// *** bench/test_branch_prediction_control.sv ***
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench for the branch prediction control block.
// ************************************************************
module test_branch_prediction_control;
	logic        sys_clk, reset, cfg_dyn_pred_en, br_valid, br_hint, br_is_count, br_ready;
	logic        pred_valid, pred_taken, pred_exact, cmp_valid, cmp_taken, mispredict, flush;
	logic        restart_valid, mv_dispatch, mv_dispatch_link, mv_in_rs0, mv_src_ready;
	logic        mv_is_link, count_valid, link_fwd_valid, act_taken;
	logic [3:0]  cmp_delay;
	logic [31:0] br_pc, br_target, br_fallthru, pred_addr, restart_addr, mv_src;
	logic [31:0] count_value, link_fwd_value;
	int          errors, n_compared, cycles;

	bpc_branch_ctrl dut (.sys_clk, .reset, .cfg_dyn_pred_en, .br_valid, .br_pc, .br_target,
		.br_fallthru, .br_hint, .br_is_count, .br_ready, .pred_valid, .pred_taken, .pred_exact,
		.pred_addr, .cmp_valid, .cmp_taken, .mispredict, .flush, .restart_valid, .restart_addr,
		.mv_dispatch, .mv_dispatch_link, .mv_in_rs0, .mv_src_ready, .mv_is_link, .mv_src,
		.count_valid, .count_value, .link_fwd_valid, .link_fwd_value);

	bpc_pipe_model pipe (.sys_clk, .reset, .pred_valid, .pred_exact, .act_taken, .cmp_delay,
		.cmp_valid, .cmp_taken);

	// Free-running core clock at 25 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// A hang is cut short well beyond the fewer than 200 cycles the run needs.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			$display("[FAIL] cycle_limit expected %0d seen %0d", 2999, cycles);
			close_out();
		end
	end

	task automatic close_out();
		if (errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Holds one branch request until accepted; the guess lands two cycles later.
	task automatic req(input logic [31:0] pc, input logic hint, input logic is_cnt);
		int n;
		@(posedge sys_clk);
		br_valid    <= 1'b1;
		br_pc       <= pc;
		br_target   <= pc + 32'h0000_0100;
		br_fallthru <= pc + 32'h0000_0004;
		br_hint     <= hint;
		br_is_count <= is_cnt;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!br_ready && n < 20);
		br_valid <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("pred_valid", 32'h1, pred_valid);
		chk("br_ready", {31'h0, is_cnt}, br_ready);
	endtask

	// Conditional branch: check the guess, let the pipe resolve it, check recovery.
	task automatic cond(input logic [31:0] pc, input logic hint, input logic act,
		input logic exp);
		int   n;
		logic bad;
		bad = act ^ exp;
		act_taken <= act;
		req(pc, hint, 1'b0);
		chk("pred_taken", {31'h0, exp}, pred_taken);
		chk("pred_exact", 32'h0, pred_exact);
		chk("pred_addr", exp ? pc + 32'h0000_0100 : pc + 32'h0000_0004, pred_addr);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!cmp_valid && n < 40);
		#1;
		chk("mispredict", {31'h0, bad}, mispredict);
		chk("flush", {31'h0, bad}, flush);
		@(posedge sys_clk);
		#1;
		chk("restart_valid", {31'h0, bad}, restart_valid);
		if (bad) begin
			chk("restart_addr", act ? pc + 32'h0000_0100 : pc + 32'h0000_0004, restart_addr);
		end
	endtask

	// Count branch: resolved exactly from the forwarded count, never mispredicted.
	task automatic cntb(input logic exp, input logic [31:0] left);
		req(32'h0000_0040, 1'b1, 1'b1);
		chk("pred_exact", 32'h1, pred_exact);
		chk("pred_taken", {31'h0, exp}, pred_taken);
		chk("pred_addr", exp ? 32'h0000_0140 : 32'h0000_0044, pred_addr);
		chk("count_value", left, count_value);
		repeat (4) begin
			@(posedge sys_clk);
			#1;
			chk("mispredict", 32'h0, mispredict);
		end
	endtask

	// A move waits in station 0 for its source, then forwards one cycle on.
	task automatic fwd(input logic link, input logic [31:0] val);
		@(posedge sys_clk);
		mv_dispatch      <= !link;
		mv_dispatch_link <= link;
		@(posedge sys_clk);
		mv_dispatch      <= 1'b0;
		mv_dispatch_link <= 1'b0;
		mv_in_rs0        <= 1'b1;
		mv_is_link       <= link;
		mv_src           <= val;
		repeat (3) @(posedge sys_clk);
		#1;
		chk("fwd_valid", 32'h0, link ? link_fwd_valid : count_valid);
		@(posedge sys_clk);
		mv_src_ready <= 1'b1;
		@(posedge sys_clk);
		mv_in_rs0    <= 1'b0;
		mv_src_ready <= 1'b0;
		mv_src       <= ~val;
		#1;
		chk("fwd_valid", 32'h1, link ? link_fwd_valid : count_valid);
		chk("fwd_value", val, link ? link_fwd_value : count_value);
	endtask

	// Static mode follows the hint and leaves the table untrained.
	task automatic s_static();
		@(posedge sys_clk);
		cmp_delay <= 4'h0;
		cond(32'h0000_0010, 1'b1, 1'b0, 1'b1);
		cmp_delay <= 4'h6;
		cond(32'h0000_0010, 1'b0, 1'b0, 1'b0);
		cond(32'h0000_0020, 1'b0, 1'b1, 1'b0);
		cond(32'h0000_0020, 1'b0, 1'b1, 1'b0);
		@(posedge sys_clk);
		cfg_dyn_pred_en <= 1'b1;
		cond(32'h0000_0020, 1'b1, 1'b0, 1'b0);
	endtask

	// Learning, a four-trip loop exit, then a shift to mostly not taken; hint opposes.
	task automatic s_dynamic();
		logic [8:0] acts;
		logic [8:0] exps;
		acts = 9'h02f;
		exps = 9'h0fe;
		cmp_delay <= 4'h1;
		for (int i = 0; i < 9; i++) begin
			cond(32'h0000_0030, ~exps[i], acts[i], exps[i]);
		end
	endtask

	// Main sequence; every input has a value at time zero.
	initial begin
		reset = 1'b1;
		cfg_dyn_pred_en = 1'b0;
		br_valid = 1'b0;
		br_pc = 32'h0000_0000;
		br_target = 32'h0000_0000;
		br_fallthru = 32'h0000_0000;
		br_hint = 1'b0;
		br_is_count = 1'b0;
		mv_dispatch = 1'b0;
		mv_dispatch_link = 1'b0;
		mv_in_rs0 = 1'b0;
		mv_src_ready = 1'b0;
		mv_is_link = 1'b0;
		mv_src = 32'h0000_0000;
		act_taken = 1'b0;
		cmp_delay = 4'h0;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		s_static();
		s_dynamic();
		fwd(1'b1, 32'h0000_1234);
		fwd(1'b0, 32'h0000_0002);
		cntb(1'b1, 32'h0000_0001);
		cntb(1'b0, 32'h0000_0000);
		close_out();
	end
endmodule
